// file: verilog/trs_stack.sv
`timescale 1ns/1ps
`include "trs_params.svh"

module trs_stack (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic call_exec,
  input wire logic return_with_literal_exec,
  input wire logic jump_exec,
  input wire logic [`TRS_ADDR_W-1:0] target_addr,
  input wire logic [`TRS_LIT_W-1:0] return_literal,
  output logic [`TRS_ADDR_W-1:0] pc,
  output logic [`TRS_LIT_W-1:0] w_literal,
  output logic w_load
);

  logic rst_sync1;
  logic rst_sync2;
  logic [`TRS_ADDR_W-1:0] level1;
  logic [`TRS_ADDR_W-1:0] level2;
  logic [`TRS_ADDR_W-1:0] next_level1;
  logic [`TRS_ADDR_W-1:0] next_pc;
  logic [`TRS_ADDR_W-1:0] pc_plus_one;
  logic load_level1;
  logic load_level2;
  trs_pkg::trs_op_type op;

  // Reset release passes two flip-flops; assertion stays asynchronous.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // A call wins over a return or jump in the same cycle, since the decoder
  // never issues two; the fixed order keeps the stack consistent if it does.
  always_comb begin
    if (call_exec) begin
      op = trs_pkg::trs_op_call;
    end else if (return_with_literal_exec) begin
      op = trs_pkg::trs_op_return;
    end else if (jump_exec) begin
      op = trs_pkg::trs_op_jump;
    end else begin
      op = trs_pkg::trs_op_step;
    end
  end

  assign pc_plus_one = pc + `TRS_PC_STEP;

  always_comb begin
    load_level1 = 1'b0;
    load_level2 = 1'b0;
    next_level1 = level1;
    case (op)
      trs_pkg::trs_op_call: begin
        load_level1 = 1'b1;
        load_level2 = 1'b1;
        next_level1 = pc_plus_one;
      end
      trs_pkg::trs_op_return: begin
        load_level1 = 1'b1;
        next_level1 = level2;
      end
      default: begin
        load_level1 = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (op)
      trs_pkg::trs_op_call: next_pc = target_addr;
      trs_pkg::trs_op_jump: next_pc = target_addr;
      trs_pkg::trs_op_return: next_pc = level1;
      default: next_pc = pc_plus_one;
    endcase
  end

  // The oldest address falls off level two on every call; nothing counts
  // depth, so overflow and underflow go unnoticed.
  trs_level u_level1 (
    .clk(clk),
    .load(load_level1),
    .data_in(next_level1),
    .data_out(level1)
  );

  // Level two is never loaded by a return, so repeated returns keep
  // delivering its last value.
  trs_level u_level2 (
    .clk(clk),
    .load(load_level2),
    .data_in(level1),
    .data_out(level2)
  );

  // This process resets only the program counter; the levels are outside it and have no reset.
  always_ff @(posedge clk or negedge rst_sync2) begin
    if (!rst_sync2) begin
      pc <= `TRS_RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2) begin
    if (!rst_sync2) begin
      w_literal <= `TRS_LIT_CLEAR;
      w_load <= 1'b0;
    end else begin
      w_load <= (op == trs_pkg::trs_op_return);
      if (op == trs_pkg::trs_op_return) begin
        w_literal <= return_literal;
      end
    end
  end

  // The levels reach no port: they are seen only through pc after a return.

endmodule

// file: verilog/trs_params.svh
`ifndef TRS_PARAMS_SVH
`define TRS_PARAMS_SVH

// Width of a stack entry and of the program counter.
`define TRS_ADDR_W 12
// Width of the literal that the return instruction carries.
`define TRS_LIT_W 8
// Program counter value after reset: the last location of program memory.
`define TRS_RESET_VECTOR 12'hFFF
// Step of the program counter in one instruction cycle.
`define TRS_PC_STEP 12'h001
// Cleared value of the working register copy.
`define TRS_LIT_CLEAR 8'h00

`endif

// file: verilog/trs_pkg.sv
package trs_pkg;

  // Effect that the executing instruction has on the program counter.
  typedef enum logic [1:0] {
    trs_op_step,
    trs_op_jump,
    trs_op_call,
    trs_op_return
  } trs_op_type;

  typedef logic [11:0] trs_addr_type;
  typedef logic [7:0] trs_lit_type;

endpackage

// file: verilog/trs_level.sv
`timescale 1ns/1ps
`include "trs_params.svh"

// One storage level of the return stack.
// It has no reset on purpose: its contents survive every kind of reset.
module trs_level (
  input wire logic clk,
  input wire logic load,
  input wire logic [`TRS_ADDR_W-1:0] data_in,
  output logic [`TRS_ADDR_W-1:0] data_out
);

  always_ff @(posedge clk) begin
    if (load) begin
      data_out <= data_in;
    end
  end

endmodule

// file: sim/trs_stack_chk.sv
`timescale 1ns/1ps
module trs_stack_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic call_exec,
  input wire logic return_with_literal_exec,
  input wire logic jump_exec,
  input wire logic [11:0] target_addr,
  input wire logic [7:0] return_literal,
  input wire logic [11:0] pc,
  input wire logic [7:0] w_literal,
  input wire logic w_load
);
  logic [2:0] up;
  logic [11:0] l1, l2;
  logic c, r, j, q;
  assign c = call_exec;
  assign r = return_with_literal_exec & ~call_exec;
  assign j = jump_exec & ~r & ~c;
  assign q = ~c & ~r & ~j;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up <= 3'h0;
    else up <= {up[1:0], 1'b1};
  end
  // Shadow levels have no reset, so a return after a reset checks retention.
  always_ff @(posedge clk) begin
    if (c) begin
      l2 <= l1;
      l1 <= pc + 12'h001;
    end else if (r) l1 <= l2;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!up[2]);
  a_step_pc: assert property (q |=> pc == $past(pc) + 12'h001) else $error("step");
  a_step_two: assert property (q ##1 q |=> pc == $past(pc, 2) + 12'h002) else $error("step2");
  a_call_dest: assert property (c |=> pc == $past(target_addr)) else $error("call");
  a_ret_addr: assert property (r |=> pc == $past(l1)) else $error("ret");
  a_ret_lit: assert property (r |=> w_load && w_literal == $past(return_literal)) else $error("lit");
  a_load_only: assert property (!r |=> !w_load) else $error("load");
  a_lit_hold: assert property (!r |=> $stable(w_literal)) else $error("hold");
  a_jump_dest: assert property (j |=> pc == $past(target_addr)) else $error("jump");
  c_calls: cover property (c ##1 c ##1 c);
  c_rets: cover property (r ##1 r ##1 r);
  c_pair: cover property (c ##1 r);
endmodule
bind trs_stack trs_stack_chk chk (.*);

// file: sim/trs_decode_model.sv
`timescale 1ns/1ps
module trs_decode_model (
  input wire trs_pkg::trs_op_type op,
  output logic call_exec,
  output logic return_with_literal_exec,
  output logic jump_exec
);
  assign call_exec = op == trs_pkg::trs_op_call;
  assign return_with_literal_exec = op == trs_pkg::trs_op_return;
  assign jump_exec = op == trs_pkg::trs_op_jump;
endmodule

// file: sim/two_level_return_stack_tb_top.sv
`timescale 1ns/1ps
module two_level_return_stack_tb_top;
  logic clk = 0, arst_n = 0, c, r, j, wl, ewl = 0;
  logic [11:0] t = 12'h000, pc, epc = 12'hFFF, e1, e2;
  logic [7:0] k = 8'h00, w, ew = 8'h00;
  logic [15:0] s = 16'h285E;
  trs_pkg::trs_op_type op = trs_pkg::trs_op_step;
  int failures = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  trs_decode_model pm (.op(op), .call_exec(c), .return_with_literal_exec(r), .jump_exec(j));
  trs_stack uut (.clk(clk), .arst_n(arst_n), .call_exec(c), .return_with_literal_exec(r),
    .jump_exec(j), .target_addr(t), .return_literal(k), .pc(pc), .w_literal(w), .w_load(wl));
  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk;
    n_checks++;
    if (!(pc === epc && w === ew && wl === ewl)) begin
      failures++;
      $display("wrong value at %0t: pc %h w %h", $time, pc, w);
    end
  endtask
  task step(input trs_pkg::trs_op_type o);
    @(negedge clk);
    chk();
    s = lfsr(s);
    op = o;
    t = s[15:4];
    k = s[11:4];
    ewl = 0;
    case (o)
      trs_pkg::trs_op_call: begin e2 = e1; e1 = epc + 12'h001; epc = t; end
      trs_pkg::trs_op_return: begin epc = e1; e1 = e2; ew = k; ewl = 1; end
      trs_pkg::trs_op_jump: epc = t;
      default: epc = epc + 12'h001;
    endcase
  endtask
  task rst;
    @(negedge clk);
    arst_n = 0;
    op = trs_pkg::trs_op_step;
    repeat (2) @(negedge clk);
    arst_n = 1;
    {epc, ew, ewl} = {12'hFFF, 8'h00, 1'b0};
    @(negedge clk);
    chk();
  endtask
  always @(posedge clk) if (++cyc > 3000) begin failures++; wrap_up(); end
  initial begin
    rst();
    repeat (3) step(trs_pkg::trs_op_call);
    repeat (3) step(trs_pkg::trs_op_return);
    repeat (2) step(trs_pkg::trs_op_call);
    rst();
    repeat (3) step(trs_pkg::trs_op_return);
    $display("directed done");
    repeat (2000) step(trs_pkg::trs_op_type'(s[1:0]));
    step(trs_pkg::trs_op_step);
    @(negedge clk);
    chk();
    $display("random done");
    wrap_up();
  end
endmodule
